// ===== rtl/hbd_pkg.sv
// constants and types for the h-bridge input mode decoder
package hbd_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int DEAD_TIME_NS       = 300;
  // least time, rounded up to whole cycles
  localparam int DEAD_CYCLES        = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DEAD_CNT_W         = 8;
  localparam logic [7:0] DEAD_LOAD  = 8'(DEAD_CYCLES);

  // ************************************************************
  // drive scheme encodings (three-state select pin)
  // ************************************************************
  typedef enum logic [2:0]
  {
    HBD_SCHEME_SPEED_DIR = 3'b001,
    HBD_SCHEME_PWM       = 3'b010,
    HBD_SCHEME_HALF      = 3'b100
  } hbd_scheme_e;

  // per half-bridge output state
  typedef enum logic [2:0]
  {
    HBD_OUT_HIZ  = 3'b001,
    HBD_OUT_LOW  = 3'b010,
    HBD_OUT_HIGH = 3'b100
  } hbd_out_e;

  localparam logic [1:0] RESET_SYNC = 2'b00;
endpackage : hbd_pkg

// ===== rtl/hbd_decoder.sv
// input mode decoder and gate sequencing for one h-bridge
`timescale 1ns/10ps

// What this block does
// - select speed/direction, pwm or half-bridge scheme from low, high or floating select.
// - capture select only on wake, keep it fixed while awake.
// - bridge inputs default low so undriven inputs leave outputs high impedance in pwm mode; the other schemes drive both outputs low.
// - insert dead time whenever a half-bridge swaps high and low transistors.
// - while asleep both outputs high impedance and bridge inputs ignored.
// - speed/direction with enable 0 drives both outputs low.
// - speed/direction enable 1: direction 1 forward, direction 0 reverse.
// - pwm mode inputs 0,0 leave both outputs high impedance.
// - pwm 0,1 reverse, 1,0 forward, 1,1 brake.
// - half-bridge mode each output follows its own input.
// - half-bridge mode disables current regulation, sense output kept.
// - bridge modes let current regulation override decoded states.
// - supply, pump undervoltage, overcurrent, thermal faults shown on fault flag.
module hbd_decoder
  import hbd_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // control pins from the motor controller
  input  wire logic low_power_enable_n,
  input  wire logic bridge_input_a,
  input  wire logic bridge_input_b,
  // three-state select pin, seen as a level and a float detect
  input  wire logic drive_scheme_select,
  input  wire logic drive_scheme_select_float,
  // current regulation request and fault sources
  input  wire logic regulation_brake,
  input  wire logic supply_undervoltage_lockout,
  input  wire logic pump_undervoltage,
  input  wire logic overcurrent_protection,
  input  wire logic thermal_shutdown,
  // gate drives for output a
  output logic      gate_high_a,
  output logic      gate_low_a,
  // gate drives for output b
  output logic      gate_high_b,
  output logic      gate_low_b,
  // status
  output logic      regulation_enabled,
  output logic      sense_enabled,
  output logic [2:0] active_scheme,
  // open-drain fault flag
  output logic      fault_flag_n_out,
  output logic      fault_flag_n_oe
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] sync_wake;
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_sel;
  logic [1:0] sync_flt;
  logic [1:0] sync_reg;
  logic [3:0] fault_s1;
  logic [3:0] fault_s2;
  logic       wake_d;
  logic       awake;
  logic       in_a;
  logic       in_b;

  // two flops on every pin; only the second flop is read by logic,
  // fault sources are merged after syncing so no gate sees a raw pin
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_wake  <= RESET_SYNC;
      sync_a     <= RESET_SYNC;
      sync_b     <= RESET_SYNC;
      sync_sel   <= RESET_SYNC;
      sync_flt   <= RESET_SYNC;
      sync_reg   <= RESET_SYNC;
      fault_s1   <= '0;
      fault_s2   <= '0;
    end
    else
    begin
      sync_wake  <= {sync_wake[0], low_power_enable_n};
      sync_a     <= {sync_a[0], bridge_input_a};
      sync_b     <= {sync_b[0], bridge_input_b};
      sync_sel   <= {sync_sel[0], drive_scheme_select};
      sync_flt   <= {sync_flt[0], drive_scheme_select_float};
      sync_reg   <= {sync_reg[0], regulation_brake};
      fault_s1   <= {thermal_shutdown, overcurrent_protection, pump_undervoltage, supply_undervoltage_lockout};
      fault_s2   <= fault_s1;
    end
  end

  assign awake = sync_wake[1];
  // inputs read low when undriven, pulldowns outside
  assign in_a  = sync_a[1];
  assign in_b  = sync_b[1];

  // wake edge detector on the synchronised level
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wake_d <= 1'b0;
    else
      wake_d <= awake;
  end

  // ************************************************************
  // scheme latch
  // ************************************************************
  hbd_scheme_e scheme;
  logic        scheme_valid;

  // sampled only at the wake edge; controller must sleep to change it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scheme       <= HBD_SCHEME_SPEED_DIR;
      scheme_valid <= 1'b0;
    end
    else if (!awake)
    begin
      scheme       <= HBD_SCHEME_SPEED_DIR; // cleared while asleep
      scheme_valid <= 1'b0;
    end
    else if (awake && !wake_d)
    begin
      scheme_valid <= 1'b1; // held until next sleep
      if (sync_flt[1])
        scheme <= HBD_SCHEME_HALF; // floating pin
      else if (sync_sel[1])
        scheme <= HBD_SCHEME_PWM;
      else
        scheme <= HBD_SCHEME_SPEED_DIR;
    end
  end

  // ************************************************************
  // truth-table decode
  // ************************************************************
  hbd_out_e want_a;
  hbd_out_e want_b;
  logic     reg_on;

  // regulation only acts in the two full-bridge schemes
  assign reg_on = scheme_valid && (scheme != HBD_SCHEME_HALF);

  always_comb
  begin
    want_a = HBD_OUT_HIZ;
    want_b = HBD_OUT_HIZ;
    if (!awake || !scheme_valid)
    begin
      want_a = HBD_OUT_HIZ; // inputs ignored asleep
      want_b = HBD_OUT_HIZ;
    end
    else
    begin
      case (scheme)
        HBD_SCHEME_SPEED_DIR:
        begin
          if (!in_a)
          begin
            want_a = HBD_OUT_LOW; // brake
            want_b = HBD_OUT_LOW;
          end
          else
          begin
            want_a = in_b ? HBD_OUT_HIGH : HBD_OUT_LOW;
            want_b = in_b ? HBD_OUT_LOW : HBD_OUT_HIGH;
          end
        end
        HBD_SCHEME_PWM:
        begin
          case ({in_a, in_b})
            2'b00:
            begin
              want_a = HBD_OUT_HIZ; // coast
              want_b = HBD_OUT_HIZ;
            end
            2'b01:
            begin
              want_a = HBD_OUT_LOW;
              want_b = HBD_OUT_HIGH;
            end
            2'b10:
            begin
              want_a = HBD_OUT_HIGH;
              want_b = HBD_OUT_LOW;
            end
            default:
            begin
              want_a = HBD_OUT_LOW;
              want_b = HBD_OUT_LOW;
            end
          endcase
        end
        default:
        begin
          want_a = in_a ? HBD_OUT_HIGH : HBD_OUT_LOW;
          want_b = in_b ? HBD_OUT_HIGH : HBD_OUT_LOW;
        end
      endcase
      // regulation forces slow-decay brake over the decode
      if (reg_on && sync_reg[1])
      begin
        want_a = HBD_OUT_LOW;
        want_b = HBD_OUT_LOW;
      end
    end
  end

  // ************************************************************
  // dead-time sequencer, one per half-bridge
  // ************************************************************
  logic [1:0] want_hi;
  logic [1:0] want_lo;
  logic [1:0] gate_hi;
  logic [1:0] gate_lo;

  assign want_hi = {want_b == HBD_OUT_HIGH, want_a == HBD_OUT_HIGH};
  assign want_lo = {want_b == HBD_OUT_LOW,  want_a == HBD_OUT_LOW};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_leg
      logic [DEAD_CNT_W-1:0] dead_cnt;
      // a new gate turns on only after both were off for the dead time;
      // turn-off is immediate so the two never overlap
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          gate_hi[gi] <= 1'b0;
          gate_lo[gi] <= 1'b0;
          dead_cnt    <= '0;
        end
        else if ((gate_hi[gi] && !want_hi[gi]) || (gate_lo[gi] && !want_lo[gi]))
        begin
          gate_hi[gi] <= 1'b0;
          gate_lo[gi] <= 1'b0;
          dead_cnt    <= DEAD_LOAD;
        end
        else if (dead_cnt != '0)
          dead_cnt <= dead_cnt - 8'h01;
        else if (!gate_hi[gi] && !gate_lo[gi])
        begin
          gate_hi[gi] <= want_hi[gi];
          gate_lo[gi] <= want_lo[gi];
        end
      end
    end
  endgenerate

  assign gate_high_a = gate_hi[0];
  assign gate_low_a  = gate_lo[0];
  assign gate_high_b = gate_hi[1];
  assign gate_low_b  = gate_lo[1];

  // ************************************************************
  // status and fault flag
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regulation_enabled <= 1'b0;
      sense_enabled      <= 1'b0;
      active_scheme      <= 3'h0;
      fault_flag_n_oe    <= 1'b0;
      fault_flag_n_out   <= 1'b0;
    end
    else
    begin
      regulation_enabled <= reg_on;
      sense_enabled      <= awake && scheme_valid; // kept in every scheme
      active_scheme      <= scheme_valid ? scheme : 3'h0;
      fault_flag_n_oe    <= |fault_s2; // pull low on any fault
      // open drain: only ever drives low, external pullup releases
      fault_flag_n_out   <= 1'b0;
    end
  end

endmodule : hbd_decoder

// ===== sim/hbd_decoder_assertions.sv
// port checker for the h-bridge decoder
`timescale 1ns/10ps
module hbd_checker
  import hbd_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // pins
  input wire logic       low_power_enable_n,
  input wire logic       supply_undervoltage_lockout,
  input wire logic       pump_undervoltage,
  input wire logic       overcurrent_protection,
  input wire logic       thermal_shutdown,
  // outputs watched
  input wire logic       gate_high_a,
  input wire logic       gate_low_a,
  input wire logic       gate_high_b,
  input wire logic       gate_low_b,
  input wire logic       regulation_enabled,
  input wire logic       sense_enabled,
  input wire logic [2:0] active_scheme,
  input wire logic       fault_flag_n_out,
  input wire logic       fault_flag_n_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // any fault source; four cycles cover the two sync stages
  wire logic flt = supply_undervoltage_lockout | pump_undervoltage | overcurrent_protection | thermal_shutdown;
  sequence s_asleep;
    !low_power_enable_n [*5];
  endsequence
  sequence s_awake;
    low_power_enable_n [*4];
  endsequence
  property p_excl_a;
    !(gate_high_a && gate_low_a);
  endproperty
  a_excl_a: assert property (p_excl_a) else $error("both gates of a on");
  property p_excl_b;
    !(gate_high_b && gate_low_b);
  endproperty
  a_excl_b: assert property (p_excl_b) else $error("both gates of b on");
  property p_dead_a;
    $fell(gate_high_a) |-> !gate_low_a [*8];
  endproperty
  a_dead_a: assert property (p_dead_a) else $error("no dead time on a");
  property p_dead_b;
    $fell(gate_low_b) |-> !gate_high_b [*8];
  endproperty
  a_dead_b: assert property (p_dead_b) else $error("no dead time on b");
  property p_sleep;
    s_asleep |-> !(gate_high_a | gate_low_a | gate_high_b | gate_low_b) && active_scheme == 3'b000;
  endproperty
  a_sleep: assert property (p_sleep) else $error("outputs driven asleep");
  property p_hold;
    s_awake ##0 active_scheme != 3'b000 |=> $stable(active_scheme);
  endproperty
  a_hold: assert property (p_hold) else $error("scheme moved while awake");
  property p_onehot;
    $onehot0(active_scheme);
  endproperty
  a_onehot: assert property (p_onehot) else $error("scheme not one-hot");
  property p_half;
    s_awake ##0 (active_scheme == 3'b100) |-> !regulation_enabled && sense_enabled;
  endproperty
  a_half: assert property (p_half) else $error("half-bridge regulation wrong");
  property p_full;
    (active_scheme == 3'b001 || active_scheme == 3'b010) [*2] |-> regulation_enabled;
  endproperty
  a_full: assert property (p_full) else $error("bridge regulation off");
  property p_fault;
    flt [*4] |-> fault_flag_n_oe && !fault_flag_n_out;
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag not pulled");
  property p_nofault;
    !flt [*4] |-> !fault_flag_n_oe;
  endproperty
  a_nofault: assert property (p_nofault) else $error("fault flag not released");
endmodule : hbd_checker

bind hbd_decoder hbd_checker chk (.clk_sys, .rst_n, .low_power_enable_n, .supply_undervoltage_lockout,
  .pump_undervoltage, .overcurrent_protection, .thermal_shutdown, .gate_high_a, .gate_low_a, .gate_high_b,
  .gate_low_b, .regulation_enabled, .sense_enabled, .active_scheme, .fault_flag_n_out, .fault_flag_n_oe);

// ===== sim/hbd_ctrl_model.sv
// controller model driving the decoder control pins
`timescale 1ns/10ps
module hbd_ctrl_model #(parameter int SLEEP_WAIT = 8)
(
  // clock
  input  wire logic clk_sys,
  // pins towards the decoder
  output logic      low_power_enable_n,
  output logic      bridge_input_a,
  output logic      bridge_input_b,
  output logic      drive_scheme_select,
  output logic      drive_scheme_select_float
);
  logic a, b, drv, sel, flt;
  logic tog = 1'b0;
  // released inputs read low through the pulldowns
  assign bridge_input_a = drv & a;
  assign bridge_input_b = drv & b;
  // a floating select has no level, so show a moving one
  assign drive_scheme_select = flt ? tog : sel;
  assign drive_scheme_select_float = flt;
  always @(negedge clk_sys) tog <= !tog;
  initial
  begin
    {low_power_enable_n, a, b, drv, sel, flt} = 6'h00;
  end
  task automatic pins(input logic na, input logic nb, input logic nd);
    @(negedge clk_sys);
    {a, b, drv} = {na, nb, nd};
  endtask : pins
  // scheme only changes through a full sleep cycle
  task automatic wake(input logic ns, input logic nf);
    @(negedge clk_sys);
    low_power_enable_n = 1'b0;
    repeat (SLEEP_WAIT) @(negedge clk_sys);
    {sel, flt} = {ns, nf};
    @(negedge clk_sys);
    low_power_enable_n = 1'b1;
  endtask : wake
endmodule : hbd_ctrl_model

// ===== sim/test_hbd_decoder.sv
// self-checking bench for the h-bridge decoder
`timescale 1ns/10ps
`define CHK(n, e, s) \
  begin \
    checks++; \
    if ((s) !== (e)) \
    begin \
      err_total++; \
      $display("BAD %s exp %h got %h", n, e, s); \
    end \
  end
module test_hbd_decoder;
  import hbd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic rb = 1'b0;
  logic [3:0] fl = 4'h0;
  wire logic low_power_enable_n, bridge_input_a, bridge_input_b, drive_scheme_select, drive_scheme_select_float;
  logic gate_high_a, gate_low_a, gate_high_b, gate_low_b, regulation_enabled, sense_enabled, foe, fout;
  logic [2:0] active_scheme;
  logic [2:0] sv;
  logic [1:0] ab;
  logic [10:0] ev;
  logic [10:0] exp_q[$];
  // every output: {flag data, flag enable, regulation, sense, scheme, gates}
  wire logic [10:0] seen = {fout, foe, regulation_enabled, sense_enabled, active_scheme,
                            gate_high_a, gate_low_a, gate_high_b, gate_low_b};
  int err_total = 0;
  int checks = 0;
  event smp;
  initial forever #2 clk_sys = ~clk_sys;
  hbd_decoder DUT (.clk_sys, .rst_n, .low_power_enable_n, .bridge_input_a, .bridge_input_b, .drive_scheme_select,
    .drive_scheme_select_float, .regulation_brake(rb), .supply_undervoltage_lockout(fl[0]),
    .pump_undervoltage(fl[1]), .overcurrent_protection(fl[2]), .thermal_shutdown(fl[3]), .gate_high_a,
    .gate_low_a, .gate_high_b, .gate_low_b, .regulation_enabled, .sense_enabled, .active_scheme,
    .fault_flag_n_out(fout), .fault_flag_n_oe(foe));
  hbd_ctrl_model m (.clk_sys, .low_power_enable_n, .bridge_input_a, .bridge_input_b, .drive_scheme_select,
    .drive_scheme_select_float);
  // ************************************************************
  // expectations and checking
  // ************************************************************
  // gates as {high a, low a, high b, low b}
  function automatic logic [3:0] gx(input logic [2:0] s, input logic a, input logic b);
    case (s)
      3'b001: gx = !a ? 4'b0101 : (b ? 4'b1001 : 4'b0110);
      3'b010: gx = {a & !b, b, b & !a, a};
      default: gx = {a, !a, b, !b};
    endcase
  endfunction : gx
  // regulation only in full-bridge schemes, sense whenever a scheme is held
  function automatic logic [10:0] ex(input logic [2:0] s, input logic [3:0] g);
    ex = {2'b00, s == 3'b001 || s == 3'b010, s != 3'b000, s, g};
  endfunction : ex
  // settle past sync and dead time, then ask the watcher to compare
  task automatic note(input logic [10:0] e);
    repeat (100) @(posedge clk_sys);
    @(negedge clk_sys);
    exp_q.push_back(e);
    ->smp;
  endtask : note
  always @(smp)
  begin
    ev = exp_q.pop_front();
    `CHK("outputs", ev, seen)
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    #100000;
    err_total++;
    results();
  end
  initial
  begin
    void'($urandom(32'h68bcb61e));
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    m.pins(1'b1, 1'b0, 1'b1);
    note(11'h000);
    for (int s = 0; s < 3; s++)
    begin
      m.wake(s == 1, s == 2);
      sv = 3'b001 << s;
      m.pins(1'b0, 1'b0, 1'b0);
      note(ex(sv, gx(sv, 1'b0, 1'b0)));
      // select moves while awake and must be ignored
      m.flt = ~m.flt;
      m.sel = ~m.sel;
      for (int i = 0; i < 7; i++)
      begin
        ab = (i < 4) ? 2'(i) : 2'($urandom);
        m.pins(ab[1], ab[0], 1'b1);
        note(ex(sv, gx(sv, ab[1], ab[0])));
      end
      rb = 1'b1;
      m.pins(1'b1, 1'b0, 1'b1);
      note(ex(sv, (s == 2) ? 4'b1001 : 4'b0101));
      rb = 1'b0;
      $display("scheme %0d done", s);
    end
    // a fresh capture after half-bridge must not keep the old scheme
    m.wake(1'b0, 1'b0);
    m.pins(1'b0, 1'b0, 1'b0);
    note(ex(3'b001, 4'b0101));
    m.low_power_enable_n = 1'b0;
    note(11'h000);
    for (int f = 0; f < 4; f++)
    begin
      fl = 4'h1 << f;
      note(11'h200);
      fl = 4'h0;
      note(11'h000);
    end
    $display("faults done");
    @(negedge clk_sys);
    results();
  end
endmodule : test_hbd_decoder
